// ==== hdl/rgc_cmd_interp.sv ====
// What this block does
// - 0x94 overwrites population table, diag reply
// - population bit one means position fitted
// - population command: 8 bytes, fixed bit layout
// - 0x95 stores relay defaults, diag reply
// - default bit one means output on
// - default command: 4 bytes, fixed bit layout
// - 0x96 reads states; bad grid gives diag
// - 0x97 returns addressing and timeout configuration
// - 0x98 stores threshold and source, diag
// - zero threshold disables count supervision
// - source 0xFF counts every sender
// - 0x99 stores start-up delay, diag reply
// - replies use group 61184, priority 6
// - replies eight bytes, only when commanded
// - diag: 0x01, answered ID, pass flag
//
// command interpreter for the grid configuration commands
// assumes an apb master in front and a can controller on the frame ports
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module rgc_cmd_interp
   import rgc_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr,
   input  wire logic               rx_frame,
   input  wire logic [7:0]         rx_sa,
   input  wire logic [3:0]         rx_len,
   input  wire logic [63:0]        rx_data,
   input  wire logic [12:0]        relay_now,
   input  wire logic [7:0]         sa_offset,
   output logic                    tx_valid,
   input  wire logic               tx_ready,
   output logic [28:0]             tx_id,
   output logic [3:0]              tx_len,
   output logic [63:0]             tx_data,
   output logic [36:0]             pop_table,
   output logic [12:0]             relay_default,
   output logic [15:0]             startup_delay,
   output logic                    msg_timeout
);
   import rgc_pkg::*;

   // ----------------------------------------------------------------
   // stored state
   // ----------------------------------------------------------------
   rgc_state_t  state;
   rgc_frame_t  cmd_buf;
   logic [3:0]  cmd_len;
   logic [7:0]  cmd_sa;
   logic [15:0] thresh;
   logic [7:0]  tmo_sa;
   logic [7:0]  own_sa;
   logic [7:0]  sa_base;
   logic [7:0]  pgn_base;
   logic        sw_go;
   logic        busy_sw;
   logic [15:0] msg_count;
   logic        cnt_expired;
   logic        tx_done_flag;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic rgc_byte_t byte_at(input rgc_frame_t f, input int unsigned i);
      byte_at = f[i*8 +: 8];
   endfunction

   function automatic rgc_frame_t diag(input rgc_byte_t id, input logic ok);
      diag = {40'h00_0000_0000, (ok ? `RGC_DIAG_OK : `RGC_DIAG_FAIL), id, `RGC_ID_DIAG};
   endfunction

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   wire rgc_byte_t cmd_id   = byte_at(cmd_buf, 0);
   wire rgc_byte_t cmd_b1   = byte_at(cmd_buf, 1);
   wire logic      grid_ok  = (cmd_b1 == `RGC_GRID_ADDR);
   wire logic is_pop   = (cmd_id == `RGC_ID_POP_WR);
   wire logic is_def   = (cmd_id == `RGC_ID_DEF_WR);
   wire logic is_rel   = (cmd_id == `RGC_ID_RELAY_RD);
   wire logic is_cfg   = (cmd_id == `RGC_ID_CFG_RD);
   wire logic is_tmo   = (cmd_id == `RGC_ID_TMO_WR);
   wire logic is_dly   = (cmd_id == `RGC_ID_DLY_WR);
   wire logic known    = is_pop | is_def | is_rel | is_cfg | is_tmo | is_dly;
   // length checks; short commands fail without side effects
   wire logic pop_ok   = is_pop && cmd_len >= `RGC_LEN_POP && grid_ok;
   wire logic def_ok   = is_def && cmd_len >= `RGC_LEN_DEF && grid_ok;
   wire logic rel_ok   = is_rel && cmd_len >= `RGC_LEN_RELAY && grid_ok;
   wire logic cfg_ok   = is_cfg && cmd_len >= `RGC_LEN_CFG;
   wire logic tmo_ok   = is_tmo && cmd_len >= `RGC_LEN_TMO;
   wire logic dly_ok   = is_dly && cmd_len >= `RGC_LEN_DLY;

   // population: fuses 24 bits bytes 2..4, relays byte 6 and 7[4:0]
   wire logic [36:0] new_pop = {cmd_buf[60:56], cmd_buf[55:48], cmd_buf[39:16]};
   // defaults: relays byte 2 and 3[4:0], one means on
   wire logic [12:0] new_def = {cmd_buf[28:24], cmd_buf[23:16]};

   // ----------------------------------------------------------------
   // reply building
   // ----------------------------------------------------------------
   wire rgc_frame_t rel_frame = {16'h0000, 3'h0, relay_default[12:8], relay_default[7:0],
                                 3'h0, relay_now[12:8], relay_now[7:0], `RGC_GRID_ADDR,
                                 `RGC_ID_RELAY_RD};
   wire rgc_frame_t rel_dly   = {startup_delay, rel_frame[47:0]};
   wire rgc_frame_t cfg_frame = {tmo_sa, thresh, pgn_base, sa_base, sa_offset,
                                 pop_table[36:32] == 5'h00 ? 8'h00 : 8'h01,
                                 `RGC_ID_CFG_RD};
   wire logic        answer_diag = ~(rel_ok | cfg_ok);
   wire logic        diag_pass   = pop_ok | def_ok | tmo_ok | dly_ok;
   wire rgc_frame_t  next_reply  = rel_ok ? rel_dly :
                                   cfg_ok ? cfg_frame :
                                   diag(cmd_id, diag_pass);
   // priority 6, pgn 61184 with destination in the pdu specific field
   wire logic [28:0] next_id = {`RGC_PRIO, `RGC_DPAGE, 1'b0, `RGC_PF, cmd_sa, own_sa};

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire logic apb_wr   = psel && penable && pwrite && pready;
   wire logic apb_rd   = psel && !penable && !pwrite;
   wire logic hit_lo   = (paddr == `RGC_OFS_CMD_LO);
   wire logic hit_hi   = (paddr == `RGC_OFS_CMD_HI);
   wire logic hit_ctl  = (paddr == `RGC_OFS_CMD_CTRL);
   wire logic mapped   = hit_lo | hit_hi | hit_ctl |
                         paddr == `RGC_OFS_RPL_LO  | paddr == `RGC_OFS_RPL_HI |
                         paddr == `RGC_OFS_RPL_STAT | paddr == `RGC_OFS_POP |
                         paddr == `RGC_OFS_DEFAULTS | paddr == `RGC_OFS_TIMEOUT |
                         paddr == `RGC_OFS_STARTUP | paddr == `RGC_OFS_RELAY_NOW |
                         paddr == `RGC_OFS_ADDRCFG;
   wire logic [31:0] rd_mux =
      paddr == `RGC_OFS_CMD_LO    ? cmd_buf[31:0] :
      paddr == `RGC_OFS_CMD_HI    ? cmd_buf[63:32] :
      paddr == `RGC_OFS_CMD_CTRL  ? {16'h0000, cmd_sa, 3'h0, busy_sw, cmd_len} :
      paddr == `RGC_OFS_RPL_LO    ? tx_data[31:0] :
      paddr == `RGC_OFS_RPL_HI    ? tx_data[63:32] :
      paddr == `RGC_OFS_RPL_STAT  ? {29'h0000_0000, state == RGC_IDLE, tx_done_flag, tx_valid} :
      paddr == `RGC_OFS_POP       ? pop_table[31:0] :
      paddr == `RGC_OFS_DEFAULTS  ? {14'h0000, pop_table[36:32], relay_default} :
      paddr == `RGC_OFS_TIMEOUT   ? {msg_count[7:0], tmo_sa, thresh} :
      paddr == `RGC_OFS_STARTUP   ? {msg_count[15:8], 7'h00, msg_timeout, startup_delay} :
      paddr == `RGC_OFS_RELAY_NOW ? {19'h0_0000, relay_now} :
      paddr == `RGC_OFS_ADDRCFG   ? {8'h00, pgn_base, sa_base, own_sa} :
                                    32'h0000_0000;

   // ----------------------------------------------------------------
   // command intake: can frame or apb-injected command
   // ----------------------------------------------------------------
   wire logic idle      = (state == RGC_IDLE);
   wire logic take_can  = idle && rx_frame && rx_len <= `RGC_LEN_REPLY;
   wire logic take_sw   = idle && !rx_frame && sw_go;
   wire logic sw_start  = apb_wr && hit_ctl && pwdata[4];

   // ----------------------------------------------------------------
   // apb slave: no wait states, pready in the first access cycle
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         prdata  <= apb_rd ? rd_mux : prdata;
         pslverr <= psel && !penable && !mapped;
      end
   end

   // ----------------------------------------------------------------
   // software command start and address configuration
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_go   <= 1'b0;
         busy_sw <= 1'b0;
         own_sa  <= `RGC_RST_OWN_SA;
         sa_base <= `RGC_RST_OWN_SA;
         pgn_base <= 8'h00;
      end else begin
         sw_go   <= take_sw ? 1'b0 : (sw_start ? 1'b1 : sw_go);
         busy_sw <= take_sw ? 1'b1 : (idle ? 1'b0 : busy_sw);
         if (apb_wr && paddr == `RGC_OFS_ADDRCFG) begin
            own_sa   <= pwdata[7:0];
            sa_base  <= pwdata[15:8];
            pgn_base <= pwdata[23:16];
         end
      end
   end

   // ----------------------------------------------------------------
   // command sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= RGC_IDLE;
         cmd_buf  <= 64'h0000_0000_0000_0000;
         cmd_len  <= 4'h0;
         cmd_sa   <= 8'h00;
         tx_valid <= 1'b0;
         tx_id    <= 29'h0000_0000;
         tx_len   <= 4'h0;
         tx_data  <= 64'h0000_0000_0000_0000;
         tx_done_flag <= 1'b0;
      end else begin
         case (state)
            RGC_IDLE: begin
               if (take_can) begin
                  cmd_buf <= rx_data;
                  cmd_len <= rx_len;
                  cmd_sa  <= rx_sa;
                  state   <= RGC_EXEC;
               end else if (apb_wr && hit_lo) begin
                  cmd_buf[31:0] <= pwdata;
               end else if (apb_wr && hit_hi) begin
                  cmd_buf[63:32] <= pwdata;
               end else if (apb_wr && hit_ctl) begin
                  cmd_len <= pwdata[3:0];
                  cmd_sa  <= pwdata[15:8];
               end
               if (take_sw) begin
                  state <= RGC_EXEC;
               end
               if (sw_start) begin
                  tx_done_flag <= 1'b0;
               end
            end
            RGC_EXEC: begin
               // replies only answer a command, never periodic
               tx_data  <= next_reply;
               tx_id    <= next_id;
               tx_len   <= `RGC_LEN_REPLY;
               tx_valid <= known | answer_diag;
               state    <= RGC_REPLY;
            end
            RGC_REPLY: begin
               if (tx_valid && tx_ready) begin
                  tx_valid     <= 1'b0;
                  tx_done_flag <= 1'b1;
                  state        <= RGC_IDLE;
               end else if (!tx_valid) begin
                  state <= RGC_IDLE;
               end
            end
            default: begin
               state <= RGC_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // stored settings, written only by a complete valid command
   // ----------------------------------------------------------------
   wire logic exec = (state == RGC_EXEC);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pop_table     <= `RGC_RST_POP;
         relay_default <= `RGC_RST_DEF;
         thresh        <= `RGC_RST_THRESH;
         tmo_sa        <= `RGC_RST_TMO_SA;
         startup_delay <= `RGC_RST_DELAY;
      end else if (exec) begin
         if (pop_ok) begin
            pop_table <= new_pop;
         end
         if (def_ok) begin
            relay_default <= new_def;
         end
         if (tmo_ok) begin
            thresh <= {byte_at(cmd_buf, 2), byte_at(cmd_buf, 1)};
            tmo_sa <= byte_at(cmd_buf, 3);
         end
         if (dly_ok) begin
            startup_delay <= {byte_at(cmd_buf, 2), byte_at(cmd_buf, 1)};
         end
      end
   end

   // ----------------------------------------------------------------
   // message-count supervision
   // ----------------------------------------------------------------
   rgc_msg_counter u_counter (
      .pclk       (pclk),
      .presetn    (presetn),
      .frame_seen (rx_frame),
      .frame_sa   (rx_sa),
      .thresh     (thresh),
      .watch_sa   (tmo_sa),
      .clear      (exec && tmo_ok),
      .count      (msg_count),
      .expired    (cnt_expired)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msg_timeout <= 1'b0;
      end else begin
         msg_timeout <= cnt_expired;
      end
   end
endmodule

// ==== inc/rgc_regs.svh ====
// constants for the relay grid configuration command interpreter
// assumes inclusion by the package, which the design modules import
`ifndef RGC_REGS_SVH
`define RGC_REGS_SVH

// ----------------------------------------------------------------
// apb register offsets (byte addresses)
// ----------------------------------------------------------------
`define RGC_OFS_CMD_LO     12'h000
`define RGC_OFS_CMD_HI     12'h004
`define RGC_OFS_CMD_CTRL   12'h008
`define RGC_OFS_RPL_LO     12'h00C
`define RGC_OFS_RPL_HI     12'h010
`define RGC_OFS_RPL_STAT   12'h014
`define RGC_OFS_POP        12'h018
`define RGC_OFS_DEFAULTS   12'h01C
`define RGC_OFS_TIMEOUT    12'h020
`define RGC_OFS_STARTUP    12'h024
`define RGC_OFS_RELAY_NOW  12'h028
`define RGC_OFS_ADDRCFG    12'h02C

// ----------------------------------------------------------------
// command and reply codes
// ----------------------------------------------------------------
`define RGC_ID_DIAG        8'h01
`define RGC_ID_POP_WR      8'h94
`define RGC_ID_DEF_WR      8'h95
`define RGC_ID_RELAY_RD    8'h96
`define RGC_ID_CFG_RD      8'h97
`define RGC_ID_TMO_WR      8'h98
`define RGC_ID_DLY_WR      8'h99
`define RGC_GRID_ADDR      8'h00
`define RGC_SA_ALL         8'hFF
`define RGC_DIAG_FAIL      8'h00
`define RGC_DIAG_OK        8'h01

// ----------------------------------------------------------------
// command and reply lengths in bytes
// ----------------------------------------------------------------
`define RGC_LEN_POP        4'h8
`define RGC_LEN_DEF        4'h4
`define RGC_LEN_RELAY      4'h2
`define RGC_LEN_CFG        4'h1
`define RGC_LEN_TMO        4'h4
`define RGC_LEN_DLY        4'h3
`define RGC_LEN_REPLY      4'h8

// ----------------------------------------------------------------
// reply frame header fields
// ----------------------------------------------------------------
`define RGC_PGN            18'h0_EF00
`define RGC_PRIO           3'h6
`define RGC_DPAGE          1'h0
`define RGC_PF             8'hEF

// ----------------------------------------------------------------
// reset values of stored settings
// ----------------------------------------------------------------
`define RGC_RST_POP        37'h00_0000_0000
`define RGC_RST_DEF        13'h0000
`define RGC_RST_THRESH     16'h0000
`define RGC_RST_TMO_SA     8'hFF
`define RGC_RST_DELAY      16'h0000
`define RGC_RST_OWN_SA     8'h80

`endif

// ==== inc/rgc_pkg.sv ====
// types shared by the command interpreter files
// assumes rgc_regs.svh on the include path
package rgc_pkg;
   `include "rgc_regs.svh"

   typedef logic [63:0] rgc_frame_t;
   typedef logic [7:0]  rgc_byte_t;

   typedef enum logic [1:0] {
      RGC_IDLE  = 2'b00,
      RGC_EXEC  = 2'b01,
      RGC_REPLY = 2'b10
   } rgc_state_t;
endpackage

// ==== hdl/rgc_msg_counter.sv ====
// counts received frames for the message-count timeout supervision
// assumes one pulse per received frame on the system clock
`timescale 1ns/1ps
module rgc_msg_counter
   import rgc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        frame_seen,
   input  wire logic [7:0]  frame_sa,
   input  wire logic [15:0] thresh,
   input  wire logic [7:0]  watch_sa,
   input  wire logic        clear,
   output logic [15:0]      count,
   output logic             expired
);
   wire logic enabled   = (thresh != `RGC_RST_THRESH);
   wire logic sa_match  = (watch_sa == `RGC_SA_ALL) ||
                          (frame_sa == watch_sa);
   wire logic counts    = enabled && frame_seen && sa_match;
   wire logic [15:0] next_count = clear ? 16'h0000 :
                                  counts ? 16'(count + 16'h0001) : count;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count   <= 16'h0000;
         expired <= 1'b0;
      end else begin
         count   <= next_count;
         expired <= enabled && (next_count >= thresh);
      end
   end
endmodule

// ==== testbench/rgc_props.sv ====
// port assertions for the grid configuration command interpreter
// assumes a bind onto rgc_cmd_interp, single clock domain
`timescale 1ns/1ps
module rgc_props (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        rx_frame,
   input wire logic        tx_valid,
   input wire logic        tx_ready,
   input wire logic [28:0] tx_id,
   input wire logic [3:0]  tx_len,
   input wire logic [63:0] tx_data,
   input wire logic [36:0] pop_table,
   input wire logic [12:0] relay_default,
   input wire logic [15:0] startup_delay
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic [3:0] since_cmd;
   wire        apb_wr = psel && penable && pwrite;
   // cycles since the last command source, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) since_cmd <= 4'hF;
      else if (rx_frame || apb_wr) since_cmd <= 4'h0;
      else if (since_cmd != 4'hF) since_cmd <= since_cmd + 4'h1;
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence
   sequence s_handshake;
      tx_valid && tx_ready;
   endsequence
   AST_APB_ANSWER: assert property (s_setup |=> s_answer) else $error("apb answer not one cycle after setup");
   AST_APB_ERR: assert property (pslverr |-> pready) else $error("slave error outside the answer cycle");
   AST_TX_CAUSE: assert property ($rose(tx_valid) |-> since_cmd <= 4'h8)
      else $error("reply raised without a command");
   AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_id))
      else $error("reply dropped or changed before acceptance");
   AST_TX_DROP: assert property (s_handshake |=> !tx_valid) else $error("reply still pending after acceptance");
   AST_TX_LEN: assert property (tx_valid |-> tx_len == 4'h8) else $error("reply length not eight");
   AST_TX_HDR: assert property (tx_valid |-> tx_id[28:16] == {3'h6, 2'h0, 8'hEF})
      else $error("reply header fields wrong");
   AST_DIAG_FLAG: assert property (tx_valid && tx_data[7:0] == 8'h01 |-> tx_data[23:16] <= 8'h01)
      else $error("diagnostic flag not zero or one");
   AST_SETTING_CAUSE: assert property (($changed(pop_table) || $changed(relay_default) || $changed(startup_delay))
      |-> $rose(tx_valid) || $past(apb_wr)) else $error("setting changed without a command");
endmodule

bind rgc_cmd_interp rgc_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .rx_frame(rx_frame), .tx_valid(tx_valid),
   .tx_ready(tx_ready), .tx_id(tx_id), .tx_len(tx_len), .tx_data(tx_data), .pop_table(pop_table),
   .relay_default(relay_default), .startup_delay(startup_delay));

// ==== testbench/rgc_can_peer.sv ====
// model of the can node that sends commands and takes replies
// assumes the interpreter frame ports on the same clock
`timescale 1ns/1ps
module rgc_can_peer (
   input  wire logic        pclk,
   input  wire logic        presetn,
   output logic             rx_frame,
   output logic [7:0]       rx_sa,
   output logic [3:0]       rx_len,
   output logic [63:0]      rx_data,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   input  wire logic [28:0] tx_id,
   input  wire logic [3:0]  tx_len,
   input  wire logic [63:0] tx_data
);
   int          slow;
   int          wait_cnt;
   int          n_rx;
   logic [28:0] got_id;
   logic [3:0]  got_len;
   logic [63:0] got_data;
   initial begin
      slow = 0;
      rx_frame = 1'b0;
      rx_sa = 8'h00;
      rx_len = 4'h0;
      rx_data = 64'h0;
   end
   // one frame, addressed to us, at most eight bytes; sa and data lines scrambled after, length held
   task automatic send(input logic [7:0] sa, input logic [3:0] len, input logic [63:0] d);
      @(posedge pclk);
      rx_frame <= 1'b1;
      rx_sa <= sa;
      rx_len <= len;
      rx_data <= d;
      @(posedge pclk);
      rx_frame <= 1'b0;
      rx_sa <= ~sa;
      rx_data <= ~d;
   endtask
   // reply acceptance, stalled for slow plus one cycles
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_ready <= 1'b0;
         wait_cnt <= 0;
         n_rx <= 0;
      end else begin
         if (tx_valid && tx_ready) begin
            got_id <= tx_id;
            got_len <= tx_len;
            got_data <= tx_data;
            n_rx <= n_rx + 1;
         end
         wait_cnt <= (tx_valid && !tx_ready) ? wait_cnt + 1 : 0;
         tx_ready <= tx_valid && wait_cnt >= slow;
      end
   end
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench for the grid configuration command interpreter
// assumes rgc_pkg compiled first and the can peer model alongside
`timescale 1ns/1ps
module tb_top;
   import rgc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic rx_frame, tx_valid, tx_ready, msg_timeout;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  rx_sa, sa_offset;
   logic [3:0]  rx_len, tx_len;
   logic [63:0] rx_data, tx_data;
   logic [12:0] relay_now, relay_default;
   logic [28:0] tx_id;
   logic [36:0] pop_table;
   logic [15:0] startup_delay;
   int          n_fail, n_compared;
   logic [7:0]  ids [5] = '{8'h94, 8'h95, 8'h96, 8'h98, 8'h99};
   logic [3:0]  lens [5] = '{4'h8, 4'h4, 4'h2, 4'h4, 4'h3};
   rgc_cmd_interp i_rgc_cmd_interp (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .rx_frame(rx_frame), .rx_sa(rx_sa), .rx_len(rx_len), .rx_data(rx_data), .relay_now(relay_now),
      .sa_offset(sa_offset), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id), .tx_len(tx_len),
      .tx_data(tx_data), .pop_table(pop_table), .relay_default(relay_default),
      .startup_delay(startup_delay), .msg_timeout(msg_timeout));
   rgc_can_peer i_rgc_can_peer (.pclk(pclk), .presetn(presetn), .rx_frame(rx_frame), .rx_sa(rx_sa),
      .rx_len(rx_len), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id),
      .tx_len(tx_len), .tx_data(tx_data));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("compared=%0d failed=%0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         n_fail++;
         final_report();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cmd(input logic [7:0] sa, input logic [3:0] len, input logic [63:0] d);
      int i;
      int n0;
      n0 = i_rgc_can_peer.n_rx;
      i_rgc_can_peer.send(sa, len, d);
      for (i = 0; i < 60 && i_rgc_can_peer.n_rx == n0; i++) @(negedge pclk);
      if (i == 60) begin
         n_fail++;
         final_report();
      end
      check({35'h0, i_rgc_can_peer.got_id}, {35'h0, 3'h6, 2'h0, 8'hEF, sa, 8'h80});
      check({60'h0, i_rgc_can_peer.got_len}, 64'h8);
   endtask
   task automatic diag(input logic [7:0] id, input logic ok);
      check({40'h0, i_rgc_can_peer.got_data[23:0]}, {40'h0, 7'h0, ok, id, 8'h01});
   endtask
   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      relay_now = 13'h0A5C;
      sa_offset = 8'h03;
      n_fail = 0;
      n_compared = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      check({27'h0, pop_table}, 64'h0);
      check({34'h0, msg_timeout, startup_delay, relay_default}, 64'h0);
      cmd(8'h21, 4'h8, 64'hF5AB_77CD_EF01_0094);
      diag(8'h94, 1'b1);
      check({27'h0, pop_table}, {27'h0, 5'h15, 8'hAB, 24'hCD_EF01});
      cmd(8'h21, 4'h4, 64'h0000_0000_F35A_0095);
      diag(8'h95, 1'b1);
      check({51'h0, relay_default}, 64'h135A);
      cmd(8'h21, 4'h4, 64'h0000_0000_0000_0195);
      diag(8'h95, 1'b0);
      cmd(8'h21, 4'h3, 64'h0000_0000_00BE_EF99);
      diag(8'h99, 1'b1);
      check({48'h0, startup_delay}, 64'hBEEF);
      for (int k = 0; k < 5; k++) begin
         cmd(8'h21, lens[k] - 4'h1, {56'h0, ids[k]});
         diag(ids[k], 1'b0);
      end
      cmd(8'h21, 4'h8, 64'h0000_0000_0000_0012);
      diag(8'h12, 1'b0);
      check({27'h0, pop_table}, {27'h0, 5'h15, 8'hAB, 24'hCD_EF01});
      check({35'h0, startup_delay, relay_default}, {35'h0, 16'hBEEF, 13'h135A});
      i_rgc_can_peer.slow = 4;
      cmd(8'h2A, 4'h2, 64'h0000_0000_0000_0096);
      check(i_rgc_can_peer.got_data, {16'hBEEF, 3'h0, 13'h135A, 3'h0, 13'h0A5C, 8'h00, 8'h96});
      i_rgc_can_peer.slow = 0;
      cmd(8'h2A, 4'h2, 64'h0000_0000_0000_0596);
      diag(8'h96, 1'b0);
      cmd(8'h21, 4'h4, 64'h0000_0000_2200_0298);
      diag(8'h98, 1'b1);
      cmd(8'h33, 4'h1, 64'h0000_0000_0000_0097);
      check(i_rgc_can_peer.got_data & 64'hFFFF_FF00_00FF_00FF, 64'h2200_0200_0003_0097);
      cmd(8'h22, 4'h1, 64'h0000_0000_0000_0097);
      check({63'h0, msg_timeout}, 64'h0);
      cmd(8'h22, 4'h1, 64'h0000_0000_0000_0097);
      check({63'h0, msg_timeout}, 64'h1);
      cmd(8'h21, 4'h4, 64'h0000_0000_FF00_0098);
      cmd(8'h33, 4'h1, 64'h0000_0000_0000_0097);
      check({63'h0, msg_timeout}, 64'h0);
      cmd(8'h21, 4'h4, 64'h0000_0000_FF00_0198);
      cmd(8'h44, 4'h1, 64'h0000_0000_0000_0097);
      check({63'h0, msg_timeout}, 64'h1);
      apb(1'b1, 12'h000, 32'h0000_0012);
      apb(1'b1, 12'h008, 32'h0000_5511);
      repeat (12) @(posedge pclk);
      diag(8'h12, 1'b0);
      check({48'h0, i_rgc_can_peer.got_id[15:0]}, 64'h5580);
      apb(1'b0, 12'h018, 32'h0);
      check({31'h0, er, rd}, 64'hABCD_EF01);
      apb(1'b1, 12'h02C, 32'h00A2_1080);
      apb(1'b0, 12'h02C, 32'h0);
      check({31'h0, er, 8'h00, rd[23:0]}, 64'h00A2_1080);
      apb(1'b1, 12'hFFC, 32'h1234_5678);
      check({63'h0, er}, 64'h1);
      apb(1'b0, 12'hFFC, 32'h0);
      check({31'h0, er, rd}, 64'h1_0000_0000);
      final_report();
   end
endmodule
